// >>> hw/gpm_pkg.sv
// Constants and types shared by the seven-pin port multiplexer
package gpm_pkg;

    // Register byte offsets on the APB slave
    localparam logic [3:0] GPM_OFS_PIN_LEVEL = 4'h0;
    localparam logic [3:0] GPM_OFS_LATCH     = 4'h4;
    localparam logic [3:0] GPM_OFS_DIR       = 4'h8;
    localparam logic [3:0] GPM_OFS_ANALOG    = 4'hC;

    // Port geometry: bits 7..1 exist, bit 0 does not
    localparam int GPM_PIN_LO  = 1;
    localparam int GPM_PIN_HI  = 7;
    localparam int GPM_REG_W   = 8;
    localparam int GPM_PCFG_W  = 4;
    localparam int GPM_SEG_W   = 6;

    // Reset values
    localparam logic [7:0] GPM_LATCH_RST = 8'h00;
    localparam logic [7:0] GPM_DIR_RST   = 8'hFE;
    localparam logic [3:0] GPM_PCFG_RST  = 4'h0;
    localparam logic [7:0] GPM_IMPL_MASK = 8'hFE;

    // Analog configuration: channel ch is analog while ch <= LAST - pcfg
    localparam logic [4:0] GPM_PCFG_LAST = 5'h0E;

    // Converter channel behind each pin, index = pin number
    localparam logic [4:0] GPM_PIN_CH [8] = '{
        5'h00, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h05
    };

    // Pins with special functions
    localparam int GPM_PIN_CMP2_OUT = 1;
    localparam int GPM_PIN_CMP1_OUT = 2;
    localparam int GPM_PIN_CMP2_B   = 3;
    localparam int GPM_PIN_CMP2_A   = 4;
    localparam int GPM_PIN_VREF     = 5;
    localparam int GPM_PIN_CMP1_B   = 5;
    localparam int GPM_PIN_CMP1_A   = 6;
    localparam int GPM_PIN_SS       = 7;

    // Enables and results from the peripherals that share the pins
    typedef struct packed {
        logic [GPM_SEG_W-1:0] seg_en;    // Bit k: segment 19+k on pin k+1
        logic                 vref_oe;   // Reference output onto pin 5
        logic                 cmp_on;    // Comparators powered
        logic                 cmp1_oe;   // Comparator 1 result onto pin 2
        logic                 cmp2_oe;   // Comparator 2 result onto pin 1
        logic                 cmp1_res;
        logic                 cmp2_res;
    } gpm_ovr_t;

    // Pin levels routed to the comparator inputs
    typedef struct packed {
        logic cmp1_in_a;
        logic cmp1_in_b;
        logic cmp2_in_a;
        logic cmp2_in_b;
    } gpm_cmp_in_t;

endpackage : gpm_pkg

// >>> hw/gpm_port.sv
// Seven-pin general-purpose port with peripheral multiplexing and APB slave
`timescale 1ns/1ps

module gpm_port
    import gpm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              SYS_RST,
    // APB slave
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Peripheral enables and results
    input  wire gpm_ovr_t          OVR,
    // Pins, index = pin number
    input  wire logic [7:1]        PIN_I,
    output logic      [7:1]        PIN_O,
    output logic      [7:1]        PIN_OE,
    // Analog and peripheral taps
    output logic      [7:1]        PIN_ANALOG_SEL,
    output gpm_cmp_in_t            CMP_IN,
    output logic                   SS_IN_N
);

    if (ADDR_W < 4) begin : g_chk
        $error("gpm_port: ADDR_W must be at least 4");
    end

    // Register state
    logic [7:0]            latch_r;
    logic [7:0]            dir_r;
    logic [GPM_PCFG_W-1:0] pcfg_r;
    logic [7:1]            pin_lvl_r;
    logic [31:0]           prdata_r;
    logic [7:1]            pin_o_r;
    logic [7:1]            pin_oe_r;
    logic [7:1]            ana_sel_r;
    gpm_cmp_in_t           cmp_in_r;
    logic                  ss_n_r;

    // Per-pin decoded state
    logic [7:1] seg_on;
    logic [7:1] vref_on;
    logic [7:1] cmp_out_on;
    logic [7:1] cmp_out_val;
    logic [7:1] ana_en;
    logic [7:1] din_en;
    logic [7:1] pin_read;
    logic [7:1] drv_o;
    logic [7:1] drv_oe;

    // Bus decode
    logic [3:0] ofs;
    logic       mapped;
    logic       setup_rd;
    logic       acc_wr;
    logic       wr_lane0;
    logic [7:0] wbyte;

    assign ofs      = PADDR[3:0];
    assign mapped   = (PADDR[ADDR_W-1:4] == '0) && (ofs[1:0] == 2'b00);
    assign setup_rd = PSEL && !PENABLE && !PWRITE;
    assign acc_wr   = PSEL && PENABLE && PWRITE && mapped;
    assign wr_lane0 = acc_wr && PSTRB[0];
    assign wbyte    = PWDATA[7:0] & GPM_IMPL_MASK;

    // Zero wait states; unmapped or misaligned addresses answer an error
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // Pin level is taken as synchronous and sampled once per clock
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_lvl_r <= '0;
        end else begin
            pin_lvl_r <= PIN_I;
        end
    end

    // Output latch: both the pin data and latch offsets land here
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            latch_r <= GPM_LATCH_RST;
        end else if (wr_lane0 && ((ofs == GPM_OFS_PIN_LEVEL) ||
                                  (ofs == GPM_OFS_LATCH))) begin
            latch_r <= wbyte;
        end
    end

    // Direction is only ever changed by software, never by overrides
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_r <= GPM_DIR_RST;
        end else if (wr_lane0 && (ofs == GPM_OFS_DIR)) begin
            dir_r <= wbyte;
        end
    end

    // Analog configuration; reset value leaves every channel analog
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pcfg_r <= GPM_PCFG_RST;
        end else if (wr_lane0 && (ofs == GPM_OFS_ANALOG)) begin
            pcfg_r <= PWDATA[GPM_PCFG_W-1:0];
        end
    end

    // Per-pin multiplexing
    for (genvar p = GPM_PIN_LO; p <= GPM_PIN_HI; p++) begin : g_pin
        if (p <= GPM_SEG_W) begin : g_seg
            assign seg_on[p] = OVR.seg_en[p-1];
        end else begin : g_noseg
            assign seg_on[p] = 1'b0;
        end

        if (p == GPM_PIN_VREF) begin : g_vref
            assign vref_on[p] = OVR.vref_oe && !seg_on[p];
        end else begin : g_novref
            assign vref_on[p] = 1'b0;
        end

        if (p == GPM_PIN_CMP2_OUT) begin : g_c2o
            assign cmp_out_on[p]  = OVR.cmp2_oe;
            assign cmp_out_val[p] = OVR.cmp2_res;
        end else if (p == GPM_PIN_CMP1_OUT) begin : g_c1o
            assign cmp_out_on[p]  = OVR.cmp1_oe;
            assign cmp_out_val[p] = OVR.cmp1_res;
        end else begin : g_nocmp
            assign cmp_out_on[p]  = 1'b0;
            assign cmp_out_val[p] = 1'b0;
        end

        // Pcfg 0Fh puts the threshold below every channel
        assign ana_en[p] = ({1'b0, pcfg_r} <= GPM_PCFG_LAST) &&
                           (GPM_PIN_CH[p] <=
                            GPM_PCFG_LAST - {1'b0, pcfg_r}) &&
                           !seg_on[p] && !vref_on[p];

        // Comparator inputs on pins 3-6 also take the digital path away
        if (p >= GPM_PIN_CMP2_B && p <= GPM_PIN_CMP1_A) begin : g_cin
            assign din_en[p] = !ana_en[p] && !seg_on[p] &&
                               !vref_on[p] && !OVR.cmp_on;
        end else begin : g_nocin
            assign din_en[p] = !ana_en[p] && !seg_on[p] &&
                               !vref_on[p];
        end

        assign pin_read[p] = din_en[p] && pin_lvl_r[p];

        always_comb begin
            if (seg_on[p] || vref_on[p]) begin
                drv_oe[p] = 1'b0;
                drv_o[p]  = 1'b0;
            end else if (cmp_out_on[p] && !dir_r[p]) begin
                drv_oe[p] = 1'b1;
                drv_o[p]  = cmp_out_val[p];
            end else begin
                drv_oe[p] = !dir_r[p];
                drv_o[p]  = latch_r[p];
            end
        end
    end

    // Pin drive and analog taps come from flip-flops, one cycle behind
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_o_r   <= '0;
            pin_oe_r  <= '0;
            ana_sel_r <= '1;
        end else begin
            pin_o_r   <= drv_o;
            pin_oe_r  <= drv_oe;
            ana_sel_r <= ana_en;
        end
    end

    // Comparator inputs see the pin only while it is an input
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmp_in_r <= '0;
        end else begin
            cmp_in_r.cmp2_in_b <= dir_r[GPM_PIN_CMP2_B] &&
                                  !seg_on[GPM_PIN_CMP2_B] &&
                                  pin_lvl_r[GPM_PIN_CMP2_B];
            cmp_in_r.cmp2_in_a <= dir_r[GPM_PIN_CMP2_A] &&
                                  !seg_on[GPM_PIN_CMP2_A] &&
                                  pin_lvl_r[GPM_PIN_CMP2_A];
            cmp_in_r.cmp1_in_b <= dir_r[GPM_PIN_CMP1_B] &&
                                  !seg_on[GPM_PIN_CMP1_B] &&
                                  !vref_on[GPM_PIN_CMP1_B] &&
                                  pin_lvl_r[GPM_PIN_CMP1_B];
            cmp_in_r.cmp1_in_a <= dir_r[GPM_PIN_CMP1_A] &&
                                  !seg_on[GPM_PIN_CMP1_A] &&
                                  pin_lvl_r[GPM_PIN_CMP1_A];
        end
    end

    // Slave select idles high (deselected) while pin 7 is an output
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ss_n_r <= 1'b1;
        end else begin
            ss_n_r <= dir_r[GPM_PIN_SS] ? pin_lvl_r[GPM_PIN_SS]
                                        : 1'b1;
        end
    end

    // Read data is captured in the setup cycle and shown in the access cycle
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            prdata_r <= '0;
        end else if (setup_rd) begin
            if (!mapped) begin
                prdata_r <= '0;
            end else if (ofs == GPM_OFS_PIN_LEVEL) begin
                prdata_r <= {24'h000000, pin_read, 1'b0};
            end else if (ofs == GPM_OFS_LATCH) begin
                prdata_r <= {24'h000000, latch_r & GPM_IMPL_MASK};
            end else if (ofs == GPM_OFS_DIR) begin
                prdata_r <= {24'h000000, dir_r & GPM_IMPL_MASK};
            end else if (ofs == GPM_OFS_ANALOG) begin
                prdata_r <= {28'h0000000, pcfg_r};
            end else begin
                prdata_r <= '0;
            end
        end
    end

    assign PRDATA         = prdata_r;
    assign PIN_O          = pin_o_r;
    assign PIN_OE         = pin_oe_r;
    assign PIN_ANALOG_SEL = ana_sel_r;
    assign CMP_IN         = cmp_in_r;
    assign SS_IN_N        = ss_n_r;

endmodule : gpm_port

// >>> tb/gpm_port_properties.sv
// Assertions on the ports of the seven-pin port multiplexer
`timescale 1ns/1ps
module gpm_chk
    import gpm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock, reset and bus
    input wire logic              MCLK,
    input wire logic              SYS_RST,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    // Peripherals and pins
    input wire gpm_ovr_t          OVR,
    input wire logic [7:1]        PIN_I,
    input wire logic [7:1]        PIN_O,
    input wire logic [7:1]        PIN_OE,
    input wire logic [7:1]        PIN_ANALOG_SEL,
    input wire logic              SS_IN_N
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    logic acc;
    assign acc = PSEL & PENABLE;

    a_ready_now : assert property (acc |-> PREADY)
        else $error("access not answered at once");
    a_err_decode : assert property (acc |-> PSLVERR ==
        (PADDR[ADDR_W-1:4] != '0 || PADDR[1:0] != 2'h0))
        else $error("error response does not match decode");
    // Analog configuration keeps its bit 0, and writes show stale read data
    a_rdata_pad : assert property (
        acc && !PWRITE && (PADDR[3:0] != GPM_OFS_ANALOG)
        |-> PRDATA[31:8] == 24'h000000 && !PRDATA[0])
        else $error("read data outside bits 7 to 1");
    a_reset_analog : assert property (
        $fell(SYS_RST) |-> PIN_ANALOG_SEL == 7'h7F && PIN_OE == 7'h00)
        else $error("pins not analog inputs after reset");
    a_seg_owns_pin : assert property (
        ((PIN_OE[6:1] | PIN_ANALOG_SEL[6:1]) & $past(OVR.seg_en)) == 6'h00)
        else $error("segment pin still used by another function");
    a_vref_pin5 : assert property ($past(OVR.vref_oe) |-> !PIN_OE[5])
        else $error("pin 5 driven while reference output on");
    a_cmp2_pin1 : assert property (
        $past(OVR.cmp2_oe && !OVR.seg_en[0]) && PIN_OE[1]
        |-> PIN_O[1] == $past(OVR.cmp2_res))
        else $error("pin 1 not carrying comparator 2 result");
    a_cmp1_pin2 : assert property (
        $past(OVR.cmp1_oe && !OVR.seg_en[1]) && PIN_OE[2]
        |-> PIN_O[2] == $past(OVR.cmp1_res))
        else $error("pin 2 not carrying comparator 1 result");
    a_ss_level : assert property (
        !SS_IN_N && !$past(SYS_RST, 2) |-> !$past(PIN_I[7], 2))
        else $error("slave select low without low pin 7");

    c_access : cover property (acc);
    c_err : cover property (PSLVERR);
    c_seg : cover property (OVR.seg_en != 6'h00);
    c_ss : cover property (!SS_IN_N);
endmodule : gpm_chk

bind gpm_port gpm_chk #(.ADDR_W(ADDR_W)) i_chk (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OVR(OVR), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .PIN_ANALOG_SEL(PIN_ANALOG_SEL), .SS_IN_N(SS_IN_N)
);

// >>> tb/gpm_board.sv
// Board model: external sources behind the seven port pins
`timescale 1ns/1ps
module gpm_board (
    // Port side
    input  wire logic [7:1] pin_o,
    input  wire logic [7:1] pin_oe,
    // Board side
    input  wire logic [7:1] ext,
    output logic      [7:1] pin_i
);
    // Sources are weak: a pin the port drives shows the port's value
    always_comb begin
        pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
    end
endmodule : gpm_board

// >>> tb/tb_top.sv
// Self-checking bench for the seven-pin port multiplexer
`timescale 1ns/1ps
module tb_top;
    import gpm_pkg::*;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, berr;
    logic        ss_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [7:1]  pin_i, pin_o, pin_oe, asel, ext;
    gpm_ovr_t    ovr;
    gpm_cmp_in_t cmp_in;
    int          err_count, checks_done;
    logic [7:1]  pat [2] = '{7'h5A, 7'h25};

    gpm_port #(.ADDR_W(12)) i_dut (.MCLK(mclk), .SYS_RST(rst),
        .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OVR(ovr), .PIN_I(pin_i), .PIN_O(pin_o),
        .PIN_OE(pin_oe), .PIN_ANALOG_SEL(asel), .CMP_IN(cmp_in),
        .SS_IN_N(ss_n));
    gpm_board i_board (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext),
        .pin_i(pin_i));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [7:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        berr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        xfer({8'h00, o}, 1'b1, d);
    endtask : wr

    task automatic rdchk(input logic [3:0] o, input logic [7:0] e);
        xfer({8'h00, o}, 1'b0, 8'h00);
        chk(rdat, {24'h000000, e});
    endtask : rdchk

    // Pin outputs lag the register write by one edge, and input taps lag the pins by two edges
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    initial begin
        #20000;
        err_count++;
        finish_test;
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = '0;
        rst   = 1'b1;
        pstrb = 4'hF;
        ovr   = '0;
        ext   = 7'h7F;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdchk(GPM_OFS_PIN_LEVEL, 8'h00);
        rdchk(GPM_OFS_LATCH, 8'h00);
        rdchk(GPM_OFS_DIR, 8'hFE);
        chk({25'h0, asel}, 32'h7F);
        $display("reset test done");
        wr(GPM_OFS_LATCH, 8'hFF);
        rdchk(GPM_OFS_LATCH, 8'hFE);
        wr(GPM_OFS_DIR, 8'h01);
        rdchk(GPM_OFS_DIR, 8'h00);
        wr(GPM_OFS_PIN_LEVEL, 8'h00);
        rdchk(GPM_OFS_LATCH, 8'h00);
        wr(GPM_OFS_PIN_LEVEL, 8'hAA);
        pstrb <= 4'h0;
        wr(GPM_OFS_LATCH, 8'h00);
        pstrb <= 4'hF;
        rdchk(GPM_OFS_LATCH, 8'hAA);
        settle;
        chk({25'h0, pin_oe}, 32'h7F);
        chk({25'h0, pin_o}, 32'h55);
        rdchk(GPM_OFS_PIN_LEVEL, 8'h00);
        $display("register test done");
        wr(GPM_OFS_ANALOG, 8'h0F);
        rdchk(GPM_OFS_ANALOG, 8'h0F);
        wr(GPM_OFS_DIR, 8'hFE);
        for (int i = 0; i < 2; i++) begin
            ext <= pat[i];
            settle;
            chk({25'h0, asel}, 32'h00);
            rdchk(GPM_OFS_PIN_LEVEL, {pat[i], 1'b0});
            chk({28'h0, cmp_in},
                {28'h0, pat[i][6], pat[i][5], pat[i][4], pat[i][3]});
            chk({31'h0, ss_n}, {31'h0, pat[i][7]});
        end
        // Comparators left on keep pins 6..3 off the digital read
        ovr.cmp_on <= 1'b1;
        settle;
        rdchk(GPM_OFS_PIN_LEVEL, 8'h02);
        $display("input test done");
        wr(GPM_OFS_DIR, 8'h00);
        wr(GPM_OFS_LATCH, 8'hFE);
        // Segment on pin 4, reference, both comparator outputs
        ovr <= '{6'h08, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        settle;
        chk({25'h0, pin_oe}, 32'h67);
        chk({25'h0, pin_o & pin_oe}, 32'h66);
        // The direction register makes every pin an output now, so no input tap may follow the pins
        chk({28'h0, cmp_in}, 32'h0);
        chk({31'h0, ss_n}, 32'h1);
        rdchk(GPM_OFS_DIR, 8'h00);
        rdchk(GPM_OFS_LATCH, 8'hFE);
        ovr.seg_en <= 6'h01;
        settle;
        chk({25'h0, pin_oe}, 32'h6E);
        $display("override test done");
        xfer(12'h010, 1'b0, 8'h00);
        chk(rdat, 32'h0);
        chk({31'h0, berr}, 32'h1);
        xfer(12'h006, 1'b1, 8'h00);
        chk({31'h0, berr}, 32'h1);
        rdchk(GPM_OFS_LATCH, 8'hFE);
        ovr <= '0;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdchk(GPM_OFS_DIR, 8'hFE);
        chk({25'h0, asel}, 32'h7F);
        $display("error and reset test done");
        finish_test;
    end
endmodule : tb_top
